// File: pkg/dpag_pkg.sv
package dpag_pkg;
	localparam int unsigned PORT_W = 8;
	// register indices; byte address is four times the index
	localparam logic [15:0] IDX_LOW_DIR = 16'hffc0;
	localparam logic [15:0] IDX_HIGH_DIR = 16'hffc1;
	localparam logic [15:0] IDX_LOW_DATA = 16'hffc2;
	localparam logic [15:0] IDX_HIGH_DATA = 16'hffc3;
	localparam logic [15:0] IDX_HIGH_PU = 16'hffd8;
	localparam int unsigned IDX_LSB = 2;
	localparam int unsigned IDX_MSB = 17;
	localparam logic [7:0] DIR_RST_EXT = 8'hff;
	localparam logic [7:0] DIR_RST_SC = 8'h00;
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [7:0] PU_RST = 8'h00;
	localparam logic [7:0] DIR_READ = 8'hff;
	localparam logic [7:0] ALL_OUT = 8'hff;
	localparam logic [7:0] ALL_IN = 8'h00;
	// edges after reset release before the mode strap is trusted
	localparam logic [2:0] STRAP_SETTLE = 3'h4;
	localparam logic [2:0] MODE_LAST_NOROM = 3'h4;
	localparam logic [2:0] MODE_LAST_ROM = 3'h6;
	localparam logic [2:0] MODE_ILLEGAL = 3'h0;
	localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;

	typedef enum logic [1:0] {
		MODE_EXT_NOROM,
		MODE_EXT_ROM,
		MODE_SINGLE
	} dpag_mode_e;

	typedef enum logic [0:0] {
		ST_SETTLE,
		ST_RUN
	} dpag_state_e;
endpackage

// File: hdl/dpag_sync3.sv
`timescale 1ns/1ps
`default_nettype none
module dpag_sync3 #(
	parameter int unsigned W = 8
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] val;
	} dpag_sync_s;

	dpag_sync_s s_q;
	dpag_sync_s s_d;

	// a bit counts once stages two and three agree; stage one feeds stage two only
	always_comb begin
		s_d = s_q;
		s_d.s1 = async_in;
		s_d.s2 = s_q.s1;
		s_d.s3 = s_q.s2;
		for (int i = 0; i < W; i++) begin
			if (s_q.s2[i] == s_q.s3[i]) begin
				s_d.val[i] = s_q.s3[i];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign sync_out = s_q.val;
endmodule
`default_nettype wire

// File: hdl/dpag_port.sv
`timescale 1ns/1ps
`default_nettype none
module dpag_port (
	input wire dpag_pkg::dpag_mode_e mode,
	input wire logic [7:0] dir,
	input wire logic [7:0] data,
	input wire logic [7:0] addr_byte,
	input wire logic [7:0] pu_ctrl,
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe,
	output logic [7:0] pu_on
);
	always_comb begin
		unique case (mode)
			dpag_pkg::MODE_EXT_NOROM: begin
				pin_out = addr_byte;
				pin_oe = dpag_pkg::ALL_OUT;
				pu_on = dpag_pkg::ALL_IN;
			end
			dpag_pkg::MODE_EXT_ROM: begin
				pin_out = addr_byte;
				pin_oe = dir;
				pu_on = pu_ctrl & ~dir;
			end
			dpag_pkg::MODE_SINGLE: begin
				pin_out = data;
				pin_oe = dir;
				pu_on = pu_ctrl & ~dir;
			end
			default: begin
				pin_out = data;
				pin_oe = dpag_pkg::ALL_IN;
				pu_on = dpag_pkg::ALL_IN;
			end
		endcase
	end
endmodule
`default_nettype wire

// File: hdl/dpag_top.sv
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module dpag_top (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [2:0] mode_pins,
	input wire logic hw_standby,
	input wire logic sw_standby,
	input wire logic [15:0] cpu_addr,
	input wire logic dram_area3_cycle,
	input wire logic [9:0] dram_mux_addr,
	input wire logic [7:0] low_pin_in,
	input wire logic [7:0] high_pin_in,
	output logic [7:0] low_pin_out,
	output logic [7:0] low_pin_oe,
	output logic [7:0] high_pin_out,
	output logic [7:0] high_pin_oe,
	output logic [7:0] high_pullup_en
);
	typedef struct packed {
		dpag_pkg::dpag_state_e st;
		logic [2:0] cnt;
		dpag_pkg::dpag_mode_e mode;
		logic [7:0] low_dir;
		logic [7:0] high_dir;
		logic [7:0] low_data;
		logic [7:0] high_data;
		logic [7:0] high_pu;
		logic [7:0] low_out;
		logic [7:0] low_oe;
		logic [7:0] high_out;
		logic [7:0] high_oe;
		logic [7:0] high_pu_on;
		logic dph;
		logic dwr;
		logic [15:0] didx;
		logic [31:0] rdata;
	} dpag_top_state_s;

	dpag_top_state_s s_q;
	dpag_top_state_s s_d;

	logic [7:0] low_pin_sync;
	logic [7:0] high_pin_sync;
	logic [4:0] ctl_sync;
	logic [2:0] mode_sync;
	logic hw_stby;
	logic sw_stby;
	logic [15:0] bus_addr;
	logic [7:0] low_out_c;
	logic [7:0] low_oe_c;
	logic [7:0] high_out_c;
	logic [7:0] high_oe_c;
	logic [7:0] high_pu_c;
	logic [15:0] a_idx;
	logic a_take;
	dpag_pkg::dpag_mode_e strap_mode;

	// pins and straps come from outside the clock domain
	dpag_sync3 #(
		.W(16)
	) u_pin_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.async_in({high_pin_in, low_pin_in}),
		.sync_out({high_pin_sync, low_pin_sync})
	);

	dpag_sync3 #(
		.W(5)
	) u_ctl_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.async_in({sw_standby, hw_standby, mode_pins}),
		.sync_out(ctl_sync)
	);

	assign mode_sync = ctl_sync[2:0];
	assign hw_stby = ctl_sync[3];
	assign sw_stby = ctl_sync[4];

	// refresh controller owns bits 9:0 during area three dram cycles
	always_comb begin
		bus_addr = cpu_addr;
		if (dram_area3_cycle) begin
			bus_addr[9:0] = dram_mux_addr;
		end
	end

	always_comb begin
		if (mode_sync == dpag_pkg::MODE_ILLEGAL) begin
			strap_mode = dpag_pkg::MODE_SINGLE;
		end else if (mode_sync <= dpag_pkg::MODE_LAST_NOROM) begin
			strap_mode = dpag_pkg::MODE_EXT_NOROM;
		end else if (mode_sync <= dpag_pkg::MODE_LAST_ROM) begin
			strap_mode = dpag_pkg::MODE_EXT_ROM;
		end else begin
			strap_mode = dpag_pkg::MODE_SINGLE;
		end
	end

	dpag_port u_low_port (
		.mode(s_q.mode),
		.dir(s_q.low_dir),
		.data(s_q.low_data),
		.addr_byte(bus_addr[7:0]),
		.pu_ctrl(dpag_pkg::PU_RST),
		.pin_out(low_out_c),
		.pin_oe(low_oe_c),
		.pu_on()
	);

	dpag_port u_high_port (
		.mode(s_q.mode),
		.dir(s_q.high_dir),
		.data(s_q.high_data),
		.addr_byte(bus_addr[15:8]),
		.pu_ctrl(s_q.high_pu),
		.pin_out(high_out_c),
		.pin_oe(high_oe_c),
		.pu_on(high_pu_c)
	);

	assign a_idx = haddr[dpag_pkg::IDX_MSB:dpag_pkg::IDX_LSB];
	assign a_take = hsel && htrans[1] && hready && (s_q.st == dpag_pkg::ST_RUN);

	always_comb begin
		s_d = s_q;
		unique case (s_q.st)
			dpag_pkg::ST_SETTLE: begin
				// strap is only trusted once it has run through the synchroniser
				if (s_q.cnt == dpag_pkg::STRAP_SETTLE) begin
					s_d.st = dpag_pkg::ST_RUN;
					s_d.mode = strap_mode;
					if (strap_mode == dpag_pkg::MODE_EXT_NOROM) begin
						s_d.low_dir = dpag_pkg::DIR_RST_EXT;
						s_d.high_dir = dpag_pkg::DIR_RST_EXT;
					end else begin
						s_d.low_dir = dpag_pkg::DIR_RST_SC;
						s_d.high_dir = dpag_pkg::DIR_RST_SC;
					end
				end else begin
					s_d.cnt = s_q.cnt + 3'h1;
				end
			end
			dpag_pkg::ST_RUN: begin
				// data phase write; the cpu is halted in software standby
				if (s_q.dph && s_q.dwr && !sw_stby) begin
					unique case (s_q.didx)
						dpag_pkg::IDX_LOW_DIR: begin
							if (s_q.mode != dpag_pkg::MODE_EXT_NOROM) begin
								s_d.low_dir = hwdata[7:0];
							end
						end
						dpag_pkg::IDX_HIGH_DIR: begin
							if (s_q.mode != dpag_pkg::MODE_EXT_NOROM) begin
								s_d.high_dir = hwdata[7:0];
							end
						end
						dpag_pkg::IDX_LOW_DATA: begin
							s_d.low_data = hwdata[7:0];
						end
						dpag_pkg::IDX_HIGH_DATA: begin
							s_d.high_data = hwdata[7:0];
						end
						dpag_pkg::IDX_HIGH_PU: begin
							s_d.high_pu = hwdata[7:0];
						end
						default: begin
						end
					endcase
				end
				if (s_q.mode == dpag_pkg::MODE_EXT_NOROM) begin
					s_d.low_dir = dpag_pkg::DIR_RST_EXT;
					s_d.high_dir = dpag_pkg::DIR_RST_EXT;
				end
				if (hw_stby) begin
					s_d.low_data = dpag_pkg::DATA_RST;
					s_d.high_data = dpag_pkg::DATA_RST;
					s_d.high_pu = dpag_pkg::PU_RST;
					if (s_q.mode == dpag_pkg::MODE_EXT_NOROM) begin
						s_d.low_dir = dpag_pkg::DIR_RST_EXT;
						s_d.high_dir = dpag_pkg::DIR_RST_EXT;
					end else begin
						s_d.low_dir = dpag_pkg::DIR_RST_SC;
						s_d.high_dir = dpag_pkg::DIR_RST_SC;
					end
				end
			end
		endcase

		// address phase; read data is built from the post-write values so that
		// a data or pull-up read right behind a write sees that write; direction reads always return 0xff
		s_d.dph = a_take;
		s_d.dwr = a_take && hwrite;
		s_d.didx = a_take ? a_idx : s_q.didx;
		if (a_take && !hwrite) begin
			s_d.rdata = '0;
			if (haddr[1:0] == 2'h0) begin
				unique case (a_idx)
					dpag_pkg::IDX_LOW_DIR: begin
						s_d.rdata[7:0] = dpag_pkg::DIR_READ;
					end
					dpag_pkg::IDX_HIGH_DIR: begin
						s_d.rdata[7:0] = dpag_pkg::DIR_READ;
					end
					dpag_pkg::IDX_LOW_DATA: begin
						s_d.rdata[7:0] = (s_d.low_dir & s_d.low_data) |
							(~s_d.low_dir & low_pin_sync);
					end
					dpag_pkg::IDX_HIGH_DATA: begin
						s_d.rdata[7:0] = (s_d.high_dir & s_d.high_data) |
							(~s_d.high_dir & high_pin_sync);
					end
					dpag_pkg::IDX_HIGH_PU: begin
						s_d.rdata[7:0] = s_d.high_pu;
					end
					default: begin
					end
				endcase
			end
		end

		// pin levels and enables freeze in software standby while pull-ups keep tracking; pins float in hardware standby
		if (s_q.st != dpag_pkg::ST_RUN || hw_stby) begin
			s_d.low_oe = dpag_pkg::ALL_IN;
			s_d.high_oe = dpag_pkg::ALL_IN;
			s_d.high_pu_on = dpag_pkg::ALL_IN;
		end else if (!sw_stby) begin
			s_d.low_out = low_out_c;
			s_d.low_oe = low_oe_c;
			s_d.high_out = high_out_c;
			s_d.high_oe = high_oe_c;
			s_d.high_pu_on = high_pu_c;
		end else begin
			s_d.high_pu_on = high_pu_c;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// wait states only while the strap settles after reset
	assign hreadyout = (s_q.st == dpag_pkg::ST_RUN);
	assign hresp = 1'b0;
	assign hrdata = s_q.rdata;
	assign low_pin_out = s_q.low_out;
	assign low_pin_oe = s_q.low_oe;
	assign high_pin_out = s_q.high_out;
	assign high_pin_oe = s_q.high_oe;
	assign high_pullup_en = s_q.high_pu_on;
endmodule
`default_nettype wire

// File: verif/dpag_pin_load.sv
`timescale 1ns/1ps
`default_nettype none
module dpag_pin_load (
	input wire logic [7:0] low_out,
	input wire logic [7:0] low_oe,
	input wire logic [7:0] high_out,
	input wire logic [7:0] high_oe,
	input wire logic [7:0] high_pu,
	input wire logic [7:0] ext_low,
	input wire logic [7:0] ext_high,
	output logic [7:0] low_in,
	output logic [7:0] high_in
);
	// driven bits echo the port, released bits show the outside load
	assign low_in = (low_out & low_oe) | (ext_low & ~low_oe);
	// pull-up only lifts a released pin, never a driven one
	assign high_in = (high_out & high_oe) | ((ext_high | high_pu) & ~high_oe);
endmodule
`default_nettype wire

// File: verif/dpag_top_props.sv
`timescale 1ns/1ps
`default_nettype none
module dpag_top_chk (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic [2:0] mode_pins,
	input wire logic hw_standby,
	input wire logic sw_standby,
	input wire logic [15:0] cpu_addr,
	input wire logic dram_area3_cycle,
	input wire logic [9:0] dram_mux_addr,
	input wire logic [7:0] low_pin_out,
	input wire logic [7:0] low_pin_oe,
	input wire logic [7:0] high_pin_out,
	input wire logic [7:0] high_pin_oe,
	input wire logic [7:0] high_pullup_en
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// sw standby freezes the pins, so these hold only while it is low
	chk_low_addr_out: assert property ((mode_pins inside {[3'h1:3'h4]} && low_pin_oe != 8'h00
		&& !$past(dram_area3_cycle)) |-> low_pin_oe == 8'hff && low_pin_out == $past(cpu_addr[7:0]))
		else $error("low port not carrying address");
	chk_high_addr_out: assert property ((mode_pins inside {[3'h1:3'h4]} && high_pin_oe != 8'h00
		&& !$past(dram_area3_cycle)) |-> high_pin_oe == 8'hff && high_pin_out == $past(cpu_addr[15:8]))
		else $error("high port not carrying address");
	chk_dram_mux_addr: assert property ((mode_pins inside {[3'h1:3'h4]} && low_pin_oe != 8'h00
		&& $past(dram_area3_cycle)) |-> low_pin_out == $past(dram_mux_addr[7:0])
		&& high_pin_out[1:0] == $past(dram_mux_addr[9:8])) else $error("dram address not muxed");
	chk_pullup_ext_off: assert property (mode_pins inside {[3'h1:3'h4]} |-> high_pullup_en == 8'h00)
		else $error("pull-up on in external mode");
	chk_pullup_input_only: assert property ((high_pullup_en & high_pin_oe) == 8'h00)
		else $error("pull-up on a driven pin");
	chk_zero_wait: assert property (hsel && htrans[1] && hready && hreadyout |=> hreadyout)
		else $error("wait state inserted");
	chk_hw_standby_off: assert property (hw_standby [*7] |-> low_pin_oe == 8'h00
		&& high_pin_oe == 8'h00 && high_pullup_en == 8'h00) else $error("pins active in hw standby");
	chk_sw_standby_hold: assert property (sw_standby [*8] |-> $stable(low_pin_out)
		&& $stable(low_pin_oe) && $stable(high_pin_out) && $stable(high_pin_oe))
		else $error("pins moved in sw standby");
endmodule
bind dpag_top dpag_top_chk chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
	.hready(hready), .hreadyout(hreadyout), .mode_pins(mode_pins), .hw_standby(hw_standby),
	.sw_standby(sw_standby), .cpu_addr(cpu_addr), .dram_area3_cycle(dram_area3_cycle),
	.dram_mux_addr(dram_mux_addr), .low_pin_out(low_pin_out), .low_pin_oe(low_pin_oe),
	.high_pin_out(high_pin_out), .high_pin_oe(high_pin_oe), .high_pullup_en(high_pullup_en));
`default_nettype wire

// File: verif/tb_dual_port_addr_gpio.sv
`timescale 1ns/1ps
`default_nettype none
module tb_dual_port_addr_gpio;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, hw_standby, sw_standby, dram_area3_cycle;
	logic [1:0] htrans;
	logic [2:0] hsize, mode_pins;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [15:0] cpu_addr;
	logic [9:0] dram_mux_addr;
	logic [7:0] low_pin_in, high_pin_in, low_pin_out, low_pin_oe, high_pin_out, high_pin_oe;
	logic [7:0] high_pullup_en;
	int errors, samples_checked;
	typedef struct {logic [15:0] idx; logic [7:0] wd; logic [7:0] exp;} dpag_row_s;
	// mode 7, high pins 7:4 read back the outside level 0x50
	dpag_row_s rows[6] = '{'{dpag_pkg::IDX_LOW_DIR, 8'hff, 8'hff},
		'{dpag_pkg::IDX_HIGH_DIR, 8'h0f, 8'hff}, '{dpag_pkg::IDX_LOW_DATA, 8'ha5, 8'ha5},
		'{dpag_pkg::IDX_HIGH_DATA, 8'h3c, 8'h5c}, '{dpag_pkg::IDX_HIGH_PU, 8'ha0, 8'ha0},
		'{16'hffc4, 8'h77, 8'h00}};
	dpag_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mode_pins(mode_pins),
		.hw_standby(hw_standby), .sw_standby(sw_standby), .cpu_addr(cpu_addr),
		.dram_area3_cycle(dram_area3_cycle), .dram_mux_addr(dram_mux_addr),
		.low_pin_in(low_pin_in), .high_pin_in(high_pin_in), .low_pin_out(low_pin_out),
		.low_pin_oe(low_pin_oe), .high_pin_out(high_pin_out), .high_pin_oe(high_pin_oe),
		.high_pullup_en(high_pullup_en));
	dpag_pin_load pm (.low_out(low_pin_out), .low_oe(low_pin_oe), .high_out(high_pin_out),
		.high_oe(high_pin_oe), .high_pu(high_pullup_en), .ext_low(8'h96), .ext_high(8'h50),
		.low_in(low_pin_in), .high_in(high_pin_in));
	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end
	task automatic end_of_test;
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// ready and read data are taken at the rising edge, before that edge's updates land
	task automatic rdy;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 100);
		if (n >= 100) begin
			errors++;
			end_of_test();
		end
		rd = hrdata;
	endtask
	task automatic ahb(input logic w, input logic [15:0] idx, input logic [7:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {14'h0, idx, 2'h0};
		rdy();
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		rdy();
	endtask
	task automatic do_reset(input logic [2:0] m);
		@(posedge hclk);
		hresetn <= 1'b0;
		mode_pins <= m;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (8) @(posedge hclk);
	endtask
	task automatic pins(input logic [7:0] loe, lo, hoe, ho, pu);
		@(negedge hclk);
		chk({24'h0, low_pin_oe}, {24'h0, loe});
		chk({24'h0, low_pin_out & loe}, {24'h0, lo});
		chk({24'h0, high_pin_oe}, {24'h0, hoe});
		chk({24'h0, high_pin_out & hoe}, {24'h0, ho});
		chk({24'h0, high_pullup_en}, {24'h0, pu});
		// back on the rising edge so the next stimulus is launched there
		@(posedge hclk);
	endtask
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		haddr = 32'h0;
		hwdata = 32'h0;
		mode_pins = 3'h7;
		hw_standby = 1'b0;
		sw_standby = 1'b0;
		cpu_addr = 16'h1234;
		dram_area3_cycle = 1'b0;
		dram_mux_addr = 10'h000;
		errors = 0;
		samples_checked = 0;
		do_reset(3'h7);
		pins(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
		foreach (rows[i]) begin
			ahb(1'b1, rows[i].idx, rows[i].wd);
			ahb(1'b0, rows[i].idx, 8'h00);
			chk(rd, {24'h0, rows[i].exp});
		end
		repeat (3) @(posedge hclk);
		pins(8'hff, 8'ha5, 8'h0f, 8'h0c, 8'ha0);
		sw_standby <= 1'b1;
		repeat (10) @(posedge hclk);
		pins(8'hff, 8'ha5, 8'h0f, 8'h0c, 8'ha0);
		sw_standby <= 1'b0;
		repeat (6) @(posedge hclk);
		ahb(1'b0, dpag_pkg::IDX_LOW_DATA, 8'h00);
		chk(rd, 32'h0000_00a5);
		hw_standby <= 1'b1;
		repeat (10) @(posedge hclk);
		pins(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
		hw_standby <= 1'b0;
		repeat (6) @(posedge hclk);
		pins(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
		ahb(1'b1, dpag_pkg::IDX_LOW_DIR, 8'hff);
		ahb(1'b0, dpag_pkg::IDX_LOW_DATA, 8'h00);
		chk(rd, 32'h0);
		ahb(1'b0, dpag_pkg::IDX_HIGH_PU, 8'h00);
		chk(rd, 32'h0);
		do_reset(3'h1);
		pins(8'hff, 8'h34, 8'hff, 8'h12, 8'h00);
		ahb(1'b1, dpag_pkg::IDX_LOW_DIR, 8'h00);
		ahb(1'b1, dpag_pkg::IDX_HIGH_DIR, 8'h00);
		ahb(1'b1, dpag_pkg::IDX_HIGH_PU, 8'hff);
		ahb(1'b0, dpag_pkg::IDX_HIGH_DIR, 8'h00);
		chk(rd, 32'h0000_00ff);
		repeat (3) @(posedge hclk);
		pins(8'hff, 8'h34, 8'hff, 8'h12, 8'h00);
		dram_area3_cycle <= 1'b1;
		dram_mux_addr <= 10'h1cd;
		repeat (2) @(posedge hclk);
		pins(8'hff, 8'hcd, 8'hff, 8'h11, 8'h00);
		dram_area3_cycle <= 1'b0;
		do_reset(3'h5);
		pins(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
		ahb(1'b1, dpag_pkg::IDX_LOW_DIR, 8'h0f);
		ahb(1'b1, dpag_pkg::IDX_HIGH_DIR, 8'hf0);
		repeat (3) @(posedge hclk);
		pins(8'h0f, 8'h04, 8'hf0, 8'h10, 8'h00);
		end_of_test();
	end
endmodule
`default_nettype wire
